// >>> hw/frc_pkg.sv
package frc_pkg;
	// Frequencies in 0.01 Hz (field-weakening limit in 0.1 Hz), percentages in 0.1 % (field-weakening level in 1 %), voltages in 1 V
	localparam int unsigned CLK_NS          = 50;
	localparam int unsigned UD_TICK_NS      = 100000;
	localparam int unsigned UD_TICK_CYC     = (UD_TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [15:0] UD_TICK_LAST    = 16'(UD_TICK_CYC - 1);
	localparam logic [15:0] UD_STEP         = 16'h0001;
	localparam logic [15:0] FREQ_ZERO       = 16'h0000;
	localparam logic [26:0] PCT_FULL        = 27'h00003e8;
	localparam logic [10:0] PCT_RANGE_MAX   = 11'h44c;
	localparam logic [13:0] VPCT_FULL       = 14'h0064;
	localparam logic [6:0]  FW_LEVEL_DEF    = 7'h50;
	localparam logic [6:0]  FW_LEVEL_MAX    = 7'h64;
	localparam logic [11:0] FW_LIMIT_MAX    = 12'h960;
	localparam logic [15:0] FW_LIMIT_SCALE  = 16'h000a;
	localparam logic [11:0] OFFS_MAX        = 12'h3e8;
	localparam logic [2:0]  CM_OLV_MAGNET   = 3'h5;
	localparam logic [3:0]  VF_CUSTOM       = 4'hf;
	localparam logic [3:0]  VF_LAST_CT      = 4'h3;
	localparam logic [9:0]  UV_200_LEVEL    = 10'h0be;
	localparam logic [9:0]  UV_400_HIGH     = 10'h1b8;
	localparam logic [9:0]  UV_400_MID      = 10'h17c;
	localparam logic [9:0]  UV_400_LOW      = 10'h15e;
	localparam logic [9:0]  VIN_400_HIGH    = 10'h1cc;
	localparam logic [9:0]  VIN_400_MID     = 10'h190;
	localparam logic [15:0] F_50HZ          = 16'h1388;
	localparam logic [15:0] F_60HZ          = 16'h1770;
	localparam logic [15:0] F_72HZ          = 16'h1c20;
	typedef enum logic [1:0] {FRC_BOOT, FRC_IDLE, FRC_RUN} frc_state_t;
endpackage

// >>> hw/frc_nv_if.sv
`timescale 1ns/1ns
interface frc_nv_if;
	logic        save_hold;
	logic        save_ud;
	logic        clr_hold;
	logic        clr_ud;
	logic [15:0] hold_val;
	logic [15:0] ud_val;
	logic        ready;
	logic [15:0] rest_hold;
	logic [15:0] rest_ud;
	logic        rest_hold_ok;
	logic        rest_ud_ok;
	modport core (output save_hold, save_ud, clr_hold, clr_ud, hold_val, ud_val,
		input ready, rest_hold, rest_ud, rest_hold_ok, rest_ud_ok);
	modport keep (input save_hold, save_ud, clr_hold, clr_ud, hold_val, ud_val,
		output ready, rest_hold, rest_ud, rest_hold_ok, rest_ud_ok);
endinterface

// >>> hw/frc_nvkeep.sv
`timescale 1ns/1ns
module frc_nvkeep
	import frc_pkg::*;
(
	input  wire logic  clk_in,
	input  wire logic  rst_n_in,
	frc_nv_if.keep     nv,
	input  wire logic [15:0] nv_hold_in,
	input  wire logic [15:0] nv_ud_in,
	input  wire logic        nv_hold_ok_in,
	input  wire logic        nv_ud_ok_in,
	output logic             nv_write_out,
	output logic [15:0]      nv_hold_out,
	output logic [15:0]      nv_ud_out,
	output logic             nv_hold_ok_out,
	output logic             nv_ud_ok_out
);
	typedef struct packed {
		logic        loaded;
		logic        wr;
		logic [15:0] hold;
		logic [15:0] ud;
		logic        hold_ok;
		logic        ud_ok;
	} frc_keep_t;

	frc_keep_t s_ff;
	frc_keep_t nxt_s;

	// Image is taken from the retained store after reset release, never under reset
	always_comb begin
		nxt_s    = s_ff;
		nxt_s.wr = 1'b0;
		if (!s_ff.loaded) begin
			nxt_s.loaded  = 1'b1;
			nxt_s.hold    = nv_hold_in;
			nxt_s.ud      = nv_ud_in;
			nxt_s.hold_ok = nv_hold_ok_in;
			nxt_s.ud_ok   = nv_ud_ok_in;
		end else begin
			if (nv.save_hold) begin
				nxt_s.hold    = nv.hold_val;
				nxt_s.hold_ok = 1'b1;
			end
			if (nv.clr_hold) begin
				nxt_s.hold    = FREQ_ZERO;
				nxt_s.hold_ok = 1'b0;
			end
			if (nv.save_ud) begin
				nxt_s.ud    = nv.ud_val;
				nxt_s.ud_ok = 1'b1;
			end
			if (nv.clr_ud) begin
				nxt_s.ud    = FREQ_ZERO;
				nxt_s.ud_ok = 1'b0;
			end
			nxt_s.wr = nv.save_hold | nv.save_ud | nv.clr_hold | nv.clr_ud;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign nv.ready        = s_ff.loaded;
	assign nv.rest_hold    = s_ff.hold;
	assign nv.rest_ud      = s_ff.ud;
	assign nv.rest_hold_ok = s_ff.hold_ok;
	assign nv.rest_ud_ok   = s_ff.ud_ok;
	assign nv_write_out    = s_ff.wr;
	assign nv_hold_out     = s_ff.hold;
	assign nv_ud_out       = s_ff.ud;
	assign nv_hold_ok_out  = s_ff.hold_ok;
	assign nv_ud_ok_out    = s_ff.ud_ok;
endmodule

// >>> hw/frc_top.sv
`timescale 1ns/1ns
module frc_top
	import frc_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        run_cmd_in,
	input  wire logic        power_fail_in,
	input  wire logic        di_ramp_hold_in,
	input  wire logic        di_up_in,
	input  wire logic        di_down_in,
	input  wire logic        di_ext_ref_in,
	input  wire logic [2:0]  di_offset_in,
	input  wire logic        di_fieldweak_in,
	input  wire logic        ramp_hold_used_in,
	input  wire logic        updown_used_in,
	input  wire logic        ref_hold_select_in,
	input  wire logic        updown_limit_select_in,
	input  wire logic [10:0] ref_lower_limit_in,
	input  wire logic [15:0] pattern_max_freq_in,
	input  wire logic [15:0] active_ref_in,
	input  wire logic [15:0] analog_ref_in,
	input  wire logic [15:0] analog_bias_in,
	input  wire logic        analog_bias_used_in,
	input  wire logic [15:0] output_freq_in,
	input  wire logic [11:0] offset_freq_one_in,
	input  wire logic [11:0] offset_freq_two_in,
	input  wire logic [11:0] offset_freq_three_in,
	input  wire logic [6:0]  fieldweak_voltage_level_in,
	input  wire logic [11:0] fieldweak_freq_limit_in,
	input  wire logic [9:0]  max_voltage_in,
	input  wire logic [9:0]  input_voltage_setting_in,
	input  wire logic        class_400_in,
	input  wire logic        vf_pattern_wr_in,
	input  wire logic [3:0]  vf_pattern_data_in,
	input  wire logic [2:0]  control_method_select_in,
	input  wire logic        param_initialize_in,
	input  wire logic        pattern_point_wr_in,
	input  wire logic [15:0] pattern_point_last_in,
	input  wire logic [15:0] nv_hold_in,
	input  wire logic [15:0] nv_ud_in,
	input  wire logic        nv_hold_ok_in,
	input  wire logic        nv_ud_ok_in,
	output logic [15:0]      freq_ref_out,
	output logic [9:0]       out_voltage_out,
	output logic             fieldweak_active_out,
	output logic [9:0]       undervoltage_level_out,
	output logic [3:0]       vf_pattern_select_out,
	output logic             vf_wr_refused_out,
	output logic             pattern_points_ro_out,
	output logic             point_wr_refused_out,
	output logic [15:0]      pattern_point_last_out,
	output logic [15:0]      vf_max_freq_out,
	output logic [15:0]      vf_base_freq_out,
	output logic             nv_write_out,
	output logic [15:0]      nv_hold_out,
	output logic [15:0]      nv_ud_out,
	output logic             nv_hold_ok_out,
	output logic             nv_ud_ok_out
);
	localparam int unsigned NSYNC = 10;

	typedef struct packed {
		logic [NSYNC-1:0] sync1;
		logic [NSYNC-1:0] sync2;
		frc_state_t       state;
		logic             synced;
		logic             hold_prev;
		logic [15:0]      held;
		logic             held_ok;
		logic [15:0]      ud;
		logic [15:0]      tick;
		logic [15:0]      fref;
		logic [9:0]       vout;
		logic             fw_on;
		logic [9:0]       uv;
		logic [3:0]       vf;
		logic             vf_ref;
		logic [15:0]      point;
		logic             pt_ref;
		logic [15:0]      vmax;
		logic [15:0]      vbase;
		logic             save_hold;
		logic             save_ud;
		logic             clr_hold;
		logic             clr_ud;
	} frc_core_t;

	frc_core_t s_ff;
	frc_core_t nxt_s;
	frc_nv_if  nv();

	function automatic logic [15:0] pct_freq(input logic [10:0] pct, input logic [15:0] fmax);
		logic [26:0] prod;
		prod = 27'(fmax) * 27'(pct);
		return 16'(prod / PCT_FULL);
	endfunction

	function automatic logic [15:0] umax(input logic [15:0] a, input logic [15:0] b);
		return (a > b) ? a : b;
	endfunction

	// Pins and other-domain levels, two stages before use
	logic [NSYNC-1:0] pins;
	assign pins = {run_cmd_in, power_fail_in, di_ramp_hold_in, di_up_in, di_down_in,
		di_ext_ref_in, di_offset_in, di_fieldweak_in};

	logic        run_s;
	logic        pfail_s;
	logic        hold_s;
	logic        up_s;
	logic        dn_s;
	logic        ext_s;
	logic [2:0]  offs_s;
	logic        fw_s;
	assign {run_s, pfail_s, hold_s, up_s, dn_s, ext_s, offs_s, fw_s} = s_ff.sync2;

	logic        hold_mode;
	logic        ud_mode;
	logic        stopping;
	logic [15:0] gen_lo;
	logic [15:0] ud_lo;
	logic [15:0] ud_hi;
	logic [15:0] base_ref;
	logic [15:0] lim_ref;
	logic signed [13:0] offs_sum;
	logic signed [31:0] offs_prod;
	logic signed [17:0] offs_freq;
	logic signed [17:0] with_offs;
	logic [15:0] fw_lim_f;
	logic [16:0] vprod;

	always_comb begin
		nxt_s           = s_ff;
		nxt_s.sync1     = pins;
		nxt_s.sync2     = s_ff.sync1;
		nxt_s.hold_prev = hold_s;
		nxt_s.save_hold = 1'b0;
		nxt_s.save_ud   = 1'b0;
		nxt_s.clr_hold  = 1'b0;
		nxt_s.clr_ud    = 1'b0;
		nxt_s.vf_ref    = 1'b0;
		nxt_s.pt_ref    = 1'b0;

		// Selection is meaningless without the matching input function
		hold_mode = ramp_hold_used_in & ~updown_used_in;
		ud_mode   = updown_used_in;
		stopping  = (s_ff.state == FRC_RUN) & (~run_s | pfail_s);

		gen_lo = pct_freq(ref_lower_limit_in, pattern_max_freq_in);
		ud_hi  = pattern_max_freq_in;
		ud_lo  = gen_lo;
		if (!updown_limit_select_in) begin
			if (analog_bias_used_in)
				ud_lo = umax(ud_lo, analog_bias_in);
			if (ext_s)
				ud_lo = umax(ud_lo, analog_ref_in);
		end

		unique case (s_ff.state)
			FRC_BOOT: begin
				// One extra edge so the synchronised hold input is valid
				nxt_s.synced = nv.ready;
				if (nv.ready && s_ff.synced) begin
					nxt_s.state = FRC_IDLE;
					if (ud_mode && ref_hold_select_in && nv.rest_ud_ok)
						nxt_s.ud = nv.rest_ud;
					else
						nxt_s.ud = FREQ_ZERO;
					// Hold input must already be closed at power-on to keep the value
					if (hold_mode && ref_hold_select_in && nv.rest_hold_ok && hold_s) begin
						nxt_s.held    = nv.rest_hold;
						nxt_s.held_ok = 1'b1;
					end else begin
						nxt_s.held     = FREQ_ZERO;
						nxt_s.held_ok  = 1'b0;
						nxt_s.clr_hold = nv.rest_hold_ok;
					end
				end
			end
			FRC_IDLE: begin
				if (run_s && !pfail_s)
					nxt_s.state = FRC_RUN;
				if (ud_mode && !run_s && (up_s ^ dn_s)) begin
					nxt_s.ud     = FREQ_ZERO;
					nxt_s.clr_ud = 1'b1;
				end
			end
			FRC_RUN: begin
				if (stopping) begin
					nxt_s.state = FRC_IDLE;
					if (ref_hold_select_in) begin
						nxt_s.save_hold = hold_mode & s_ff.held_ok;
						nxt_s.save_ud   = ud_mode;
					end else begin
						if (hold_mode) begin
							nxt_s.held    = FREQ_ZERO;
							nxt_s.held_ok = 1'b0;
						end
						if (ud_mode)
							nxt_s.ud = FREQ_ZERO;
					end
				end else begin
					if (hold_mode && hold_s && !s_ff.held_ok) begin
						nxt_s.held    = output_freq_in;
						nxt_s.held_ok = 1'b1;
					end
					// Rate set by a tick so a held key ramps instead of jumping
					if (ud_mode && (up_s ^ dn_s)) begin
						if (s_ff.tick == UD_TICK_LAST) begin
							nxt_s.tick = '0;
							if (up_s)
								nxt_s.ud = (s_ff.ud > ud_hi - UD_STEP) ? ud_hi : s_ff.ud + UD_STEP;
							else
								nxt_s.ud = (s_ff.ud < UD_STEP) ? FREQ_ZERO : s_ff.ud - UD_STEP;
						end else begin
							nxt_s.tick = s_ff.tick + 16'h0001;
						end
					end else begin
						nxt_s.tick = '0;
					end
				end
			end
		endcase

		// Release of the hold input discards the value, running or not
		if (hold_mode && s_ff.hold_prev && !hold_s && s_ff.state != FRC_BOOT) begin
			nxt_s.held     = FREQ_ZERO;
			nxt_s.held_ok  = 1'b0;
			nxt_s.clr_hold = 1'b1;
		end

		if (ud_mode) begin
			if (nxt_s.ud > ud_hi)
				nxt_s.ud = ud_hi;
			if (s_ff.state == FRC_RUN && !stopping && nxt_s.ud < ud_lo)
				nxt_s.ud = ud_lo;
		end

		// Reference source: up/down, held value, else active reference
		if (ud_mode && !(ext_s && updown_limit_select_in))
			base_ref = s_ff.ud;
		else if (hold_mode && s_ff.held_ok)
			base_ref = s_ff.held;
		else
			base_ref = active_ref_in;

		offs_sum = '0;
		if (offs_s[0])
			offs_sum = offs_sum + 14'(signed'(offset_freq_one_in));
		if (offs_s[1])
			offs_sum = offs_sum + 14'(signed'(offset_freq_two_in));
		if (offs_s[2])
			offs_sum = offs_sum + 14'(signed'(offset_freq_three_in));
		offs_prod = 32'(offs_sum) * signed'({16'h0000, pattern_max_freq_in});
		offs_freq = 18'(offs_prod / signed'(32'(PCT_FULL)));
		with_offs = signed'({2'b00, base_ref}) + offs_freq;
		if (with_offs < 0)
			lim_ref = FREQ_ZERO;
		else if (with_offs > signed'({2'b00, pattern_max_freq_in}))
			lim_ref = pattern_max_freq_in;
		else
			lim_ref = with_offs[15:0];
		if (lim_ref < gen_lo)
			lim_ref = gen_lo;
		nxt_s.fref = (s_ff.state == FRC_BOOT) ? FREQ_ZERO : lim_ref;

		fw_lim_f    = 16'(fieldweak_freq_limit_in) * FW_LIMIT_SCALE;
		nxt_s.fw_on = fw_s && (output_freq_in > fw_lim_f) &&
			(output_freq_in == s_ff.fref);
		vprod       = 17'(max_voltage_in) * 17'(fieldweak_voltage_level_in);
		nxt_s.vout  = nxt_s.fw_on ? 10'(vprod / 17'(VPCT_FULL)) : max_voltage_in;

		if (!class_400_in)
			nxt_s.uv = UV_200_LEVEL;
		else if (input_voltage_setting_in > VIN_400_HIGH)
			nxt_s.uv = UV_400_HIGH;
		else if (input_voltage_setting_in >= VIN_400_MID)
			nxt_s.uv = UV_400_MID;
		else
			nxt_s.uv = UV_400_LOW;

		// Initialization never touches the pattern code
		if (vf_pattern_wr_in && !param_initialize_in) begin
			if (vf_pattern_data_in != VF_CUSTOM &&
				control_method_select_in == CM_OLV_MAGNET)
				nxt_s.vf_ref = 1'b1;
			else
				nxt_s.vf = vf_pattern_data_in;
		end

		if (pattern_point_wr_in) begin
			if (s_ff.vf != VF_CUSTOM)
				nxt_s.pt_ref = 1'b1;
			else
				nxt_s.point = pattern_point_last_in;
		end

		unique case (s_ff.vf)
			4'h0: begin
				nxt_s.vmax  = F_50HZ;
				nxt_s.vbase = F_50HZ;
			end
			4'h1: begin
				nxt_s.vmax  = F_60HZ;
				nxt_s.vbase = F_60HZ;
			end
			4'h2: begin
				nxt_s.vmax  = F_60HZ;
				nxt_s.vbase = F_50HZ;
			end
			4'h3: begin
				nxt_s.vmax  = F_72HZ;
				nxt_s.vbase = F_60HZ;
			end
			default: begin
				// Curves beyond the constant-torque set take the pattern maximum as both maximum and base frequency
				nxt_s.vmax  = pattern_max_freq_in;
				nxt_s.vbase = pattern_max_freq_in;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			s_ff       <= '0;
			s_ff.state <= FRC_BOOT;
			s_ff.vf    <= VF_CUSTOM;
			s_ff.uv    <= UV_200_LEVEL;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign nv.save_hold = s_ff.save_hold;
	assign nv.save_ud   = s_ff.save_ud;
	assign nv.clr_hold  = s_ff.clr_hold;
	assign nv.clr_ud    = s_ff.clr_ud;
	assign nv.hold_val  = s_ff.held;
	assign nv.ud_val    = s_ff.ud;

	frc_nvkeep u_keep (
		.clk_in         (clk_in),
		.rst_n_in       (rst_n_in),
		.nv             (nv.keep),
		.nv_hold_in     (nv_hold_in),
		.nv_ud_in       (nv_ud_in),
		.nv_hold_ok_in  (nv_hold_ok_in),
		.nv_ud_ok_in    (nv_ud_ok_in),
		.nv_write_out   (nv_write_out),
		.nv_hold_out    (nv_hold_out),
		.nv_ud_out      (nv_ud_out),
		.nv_hold_ok_out (nv_hold_ok_out),
		.nv_ud_ok_out   (nv_ud_ok_out)
	);

	assign freq_ref_out           = s_ff.fref;
	assign out_voltage_out        = s_ff.vout;
	assign fieldweak_active_out   = s_ff.fw_on;
	assign undervoltage_level_out = s_ff.uv;
	assign vf_pattern_select_out  = s_ff.vf;
	assign vf_wr_refused_out      = s_ff.vf_ref;
	assign pattern_points_ro_out  = (s_ff.vf != VF_CUSTOM);
	assign point_wr_refused_out   = s_ff.pt_ref;
	assign pattern_point_last_out = s_ff.point;
	assign vf_max_freq_out        = s_ff.vmax;
	assign vf_base_freq_out       = s_ff.vbase;
endmodule

// >>> verification/frc_top_assertions.sv
`timescale 1ns/1ns
module frc_top_checker
	import frc_pkg::*;
(
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	input wire logic        class_400_in,
	input wire logic [9:0]  input_voltage_setting_in,
	input wire logic [9:0]  undervoltage_level_out,
	input wire logic        vf_pattern_wr_in,
	input wire logic [3:0]  vf_pattern_data_in,
	input wire logic [2:0]  control_method_select_in,
	input wire logic        param_initialize_in,
	input wire logic [3:0]  vf_pattern_select_out,
	input wire logic        vf_wr_refused_out,
	input wire logic        pattern_points_ro_out,
	input wire logic        pattern_point_wr_in,
	input wire logic        point_wr_refused_out,
	input wire logic [15:0] pattern_point_last_out,
	input wire logic [15:0] vf_max_freq_out,
	input wire logic [15:0] vf_base_freq_out,
	input wire logic        fieldweak_active_out,
	input wire logic [15:0] output_freq_in,
	input wire logic [11:0] fieldweak_freq_limit_in,
	input wire logic [9:0]  out_voltage_out,
	input wire logic [9:0]  max_voltage_in,
	input wire logic [6:0]  fieldweak_voltage_level_in
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// First edge after release still shows the reset level, so skip it
	chk_uv_class200: assert property ($past(rst_n_in) && !$past(class_400_in)
		|-> undervoltage_level_out == UV_200_LEVEL) else $error("uv level wrong, 200 class");
	chk_uv_high400: assert property ($past(rst_n_in) && $past(class_400_in)
		&& $past(input_voltage_setting_in) > VIN_400_HIGH |-> undervoltage_level_out == UV_400_HIGH)
		else $error("uv level wrong, high setting");
	chk_uv_low400: assert property ($past(rst_n_in) && $past(class_400_in)
		&& $past(input_voltage_setting_in) < VIN_400_MID |-> undervoltage_level_out == UV_400_LOW)
		else $error("uv level wrong, low setting");
	chk_vf_refuse: assert property (vf_pattern_wr_in && !param_initialize_in
		&& control_method_select_in == CM_OLV_MAGNET && vf_pattern_data_in != VF_CUSTOM
		|=> vf_wr_refused_out && $stable(vf_pattern_select_out)) else $error("vf write not refused");
	chk_init_keeps: assert property (param_initialize_in && vf_pattern_wr_in
		|=> $stable(vf_pattern_select_out)) else $error("pattern changed during init");
	chk_ro_decode: assert property (pattern_points_ro_out == (vf_pattern_select_out != VF_CUSTOM))
		else $error("read-only flag does not follow pattern");
	chk_point_refuse: assert property (pattern_point_wr_in && pattern_points_ro_out
		|=> point_wr_refused_out && $stable(pattern_point_last_out)) else $error("point write let in");
	chk_ct_curve: assert property (vf_pattern_wr_in && !param_initialize_in
		&& vf_pattern_data_in == VF_LAST_CT && control_method_select_in != CM_OLV_MAGNET
		|-> ##2 vf_max_freq_out == F_72HZ && vf_base_freq_out == F_60HZ) else $error("code 3 curve wrong");
	chk_fw_gate: assert property (fieldweak_active_out |-> $past(output_freq_in) >
		$past(fieldweak_freq_limit_in) * FW_LIMIT_SCALE) else $error("field weakening below limit");
	chk_fw_volt: assert property (fieldweak_active_out |-> 32'(out_voltage_out) ==
		(32'($past(max_voltage_in)) * 32'($past(fieldweak_voltage_level_in))) / 32'h64)
		else $error("field weakening voltage wrong");
endmodule

bind frc_top frc_top_checker frc_top_checker_i (.*);

// >>> verification/frc_nv_store.sv
`timescale 1ns/1ns
module frc_nv_store (
	input  wire logic        clk_in,
	input  wire logic        wr_in,
	input  wire logic [15:0] hold_in,
	input  wire logic [15:0] ud_in,
	input  wire logic        hold_ok_in,
	input  wire logic        ud_ok_in,
	output logic [15:0]      hold_out,
	output logic [15:0]      ud_out,
	output logic             hold_ok_out,
	output logic             ud_ok_out
);
	// No reset input: the image must outlive the core's reset
	initial begin
		hold_out = 16'h0000;
		ud_out = 16'h0000;
		hold_ok_out = 1'b0;
		ud_ok_out = 1'b0;
	end
	always @(posedge clk_in) begin
		if (wr_in) begin
			hold_out <= hold_in;
			ud_out <= ud_in;
			hold_ok_out <= hold_ok_in;
			ud_ok_out <= ud_ok_in;
		end
	end
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ns
module tb_top
	import frc_pkg::*;
;
	logic clk_in, rst_n_in, run_cmd_in, power_fail_in, di_ramp_hold_in, di_up_in, di_down_in;
	logic di_ext_ref_in, di_fieldweak_in, ramp_hold_used_in, updown_used_in, ref_hold_select_in;
	logic updown_limit_select_in, analog_bias_used_in, class_400_in, vf_pattern_wr_in;
	logic param_initialize_in, pattern_point_wr_in, nv_hold_ok_in, nv_ud_ok_in;
	logic [2:0] di_offset_in, control_method_select_in;
	logic [3:0] vf_pattern_data_in, vf_pattern_select_out;
	logic [6:0] fieldweak_voltage_level_in;
	logic [9:0] max_voltage_in, input_voltage_setting_in, out_voltage_out, undervoltage_level_out;
	logic [10:0] ref_lower_limit_in;
	logic [11:0] offset_freq_one_in, offset_freq_two_in, offset_freq_three_in;
	logic [11:0] fieldweak_freq_limit_in;
	logic [15:0] pattern_max_freq_in, active_ref_in, analog_ref_in, analog_bias_in, output_freq_in;
	logic [15:0] pattern_point_last_in, nv_hold_in, nv_ud_in, freq_ref_out, pattern_point_last_out;
	logic [15:0] vf_max_freq_out, vf_base_freq_out, nv_hold_out, nv_ud_out;
	logic fieldweak_active_out, vf_wr_refused_out, pattern_points_ro_out, point_wr_refused_out;
	logic nv_write_out, nv_hold_ok_out, nv_ud_ok_out;
	int n_errors = 0;
	int tests_run = 0;
	int cyc = 0;

	frc_top frc_top_i (.*);
	frc_nv_store frc_nv_store_i (.clk_in(clk_in), .wr_in(nv_write_out), .hold_in(nv_hold_out),
		.ud_in(nv_ud_out), .hold_ok_in(nv_hold_ok_out), .ud_ok_in(nv_ud_ok_out),
		.hold_out(nv_hold_in), .ud_out(nv_ud_in), .hold_ok_out(nv_hold_ok_in),
		.ud_ok_out(nv_ud_ok_in));

	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Generous ceiling; the up/down walk alone needs about 4500 cycles
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			give_verdict();
		end
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
		#5;
	endtask

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic vf_write(input logic [3:0] code, output logic refused);
		vf_pattern_wr_in = 1'b1;
		vf_pattern_data_in = code;
		step(1);
		refused = vf_wr_refused_out;
		vf_pattern_wr_in = 1'b0;
		step(2);
	endtask

	task automatic point_write(input int wait_n);
		pattern_point_wr_in = 1'b1;
		step(1);
		pattern_point_wr_in = 1'b0;
		step(wait_n);
	endtask

	task automatic wait_save();
		int k;
		k = 0;
		while (nv_write_out !== 1'b1 && k < 20) begin
			step(1);
			k++;
		end
		cmp(16'(nv_write_out), 16'h0001);
		step(2);
	endtask

	task automatic t_uv();
		logic [9:0] vin [5] = '{10'h0e6, 10'h1cd, 10'h1cc, 10'h190, 10'h18f};
		logic [9:0] lvl [5] = '{UV_200_LEVEL, UV_400_HIGH, UV_400_MID, UV_400_MID, UV_400_LOW};
		for (int i = 0; i < 5; i++) begin
			class_400_in = (i != 0);
			input_voltage_setting_in = vin[i];
			step(2);
			cmp(16'(undervoltage_level_out), 16'(lvl[i]));
		end
	endtask

	task automatic t_vf();
		logic r;
		logic [15:0] mx [4] = '{F_50HZ, F_60HZ, F_60HZ, F_72HZ};
		logic [15:0] bs [4] = '{F_50HZ, F_60HZ, F_50HZ, F_60HZ};
		for (int c = 0; c < 15; c++) begin
			vf_write(4'(c), r);
			cmp(vf_max_freq_out, (c < 4) ? mx[c] : pattern_max_freq_in);
			cmp(vf_base_freq_out, (c < 4) ? bs[c] : pattern_max_freq_in);
			cmp(16'(pattern_points_ro_out), 16'h0001);
		end
		pattern_point_last_in = 16'h1234;
		point_write(0);
		cmp(16'(point_wr_refused_out), 16'h0001);
		vf_write(VF_CUSTOM, r);
		cmp(16'(pattern_points_ro_out), 16'h0000);
		cmp(vf_max_freq_out, pattern_max_freq_in);
		point_write(2);
		cmp(pattern_point_last_out, 16'h1234);
	endtask

	task automatic t_magnet();
		logic r;
		control_method_select_in = CM_OLV_MAGNET;
		vf_write(4'h2, r);
		cmp(16'(r), 16'h0001);
		cmp(16'(vf_pattern_select_out), 16'h000f);
		control_method_select_in = 3'h0;
		param_initialize_in = 1'b1;
		vf_write(4'h1, r);
		param_initialize_in = 1'b0;
		cmp(16'(vf_pattern_select_out), 16'h000f);
	endtask

	task automatic t_offsets();
		int s;
		active_ref_in = 16'h0bb8;
		offset_freq_one_in = 12'h064;
		offset_freq_two_in = 12'hfce;
		offset_freq_three_in = 12'h0c8;
		for (int m = 0; m < 8; m++) begin
			di_offset_in = 3'(m);
			step(5);
			s = (m[0] ? 100 : 0) + (m[1] ? -50 : 0) + (m[2] ? 200 : 0);
			cmp(freq_ref_out, 16'(3000 + s * 6));
		end
		di_offset_in = 3'h0;
		active_ref_in = 16'h03e8;
		ref_lower_limit_in = 11'h1f4;
		step(4);
		cmp(freq_ref_out, 16'h0bb8);
		ref_lower_limit_in = 11'h000;
		active_ref_in = 16'h0bb8;
		step(4);
	endtask

	task automatic t_fw();
		fieldweak_freq_limit_in = 12'h064;
		output_freq_in = 16'h0bb8;
		di_fieldweak_in = 1'b1;
		step(6);
		cmp(16'(fieldweak_active_out), 16'h0001);
		cmp(16'(out_voltage_out), 16'h0140);
		output_freq_in = 16'h0bb7;
		step(3);
		cmp(16'(fieldweak_active_out), 16'h0000);
		output_freq_in = 16'h0bb8;
		fieldweak_freq_limit_in = 12'h12c;
		step(3);
		cmp(16'(fieldweak_active_out), 16'h0000);
		di_fieldweak_in = 1'b0;
	endtask

	task automatic t_hold();
		ramp_hold_used_in = 1'b1;
		ref_hold_select_in = 1'b1;
		output_freq_in = 16'h07d0;
		run_cmd_in = 1'b1;
		di_ramp_hold_in = 1'b1;
		step(6);
		cmp(freq_ref_out, 16'h07d0);
		run_cmd_in = 1'b0;
		wait_save();
		cmp(nv_hold_out, 16'h07d0);
		// Power cycle with the hold input kept closed
		rst_n_in = 1'b0;
		step(3);
		rst_n_in = 1'b1;
		step(6);
		cmp(freq_ref_out, 16'h07d0);
		di_ramp_hold_in = 1'b0;
		step(5);
		cmp(16'(nv_hold_ok_out), 16'h0000);
		cmp(freq_ref_out, 16'h0bb8);
		ref_hold_select_in = 1'b0;
		{run_cmd_in, di_ramp_hold_in} = 2'b11;
		step(6);
		cmp(freq_ref_out, 16'h07d0);
		power_fail_in = 1'b1;
		step(6);
		cmp(freq_ref_out, 16'h0bb8);
		{run_cmd_in, power_fail_in, di_ramp_hold_in, ramp_hold_used_in} = 4'h0;
		step(4);
	endtask

	task automatic t_updown();
		logic [15:0] v;
		updown_used_in = 1'b1;
		ref_hold_select_in = 1'b1;
		di_ext_ref_in = 1'b1;
		run_cmd_in = 1'b1;
		di_up_in = 1'b1;
		step(4500);
		di_up_in = 1'b0;
		step(4);
		v = freq_ref_out;
		cmp(16'(v inside {16'h0002, 16'h0003}), 16'h0001);
		run_cmd_in = 1'b0;
		wait_save();
		cmp(nv_ud_out, v);
		cmp(16'(nv_ud_ok_out), 16'h0001);
		// Power cycle: only the retained image carries the value across
		rst_n_in = 1'b0;
		step(3);
		rst_n_in = 1'b1;
		step(4);
		run_cmd_in = 1'b1;
		step(6);
		cmp(freq_ref_out, v);
		run_cmd_in = 1'b0;
		wait_save();
		di_down_in = 1'b1;
		step(4);
		di_down_in = 1'b0;
		step(4);
		run_cmd_in = 1'b1;
		step(6);
		cmp(freq_ref_out, 16'h0000);
		cmp(16'(nv_ud_ok_out), 16'h0000);
		analog_bias_used_in = 1'b1;
		analog_bias_in = 16'h09c4;
		step(4);
		cmp(freq_ref_out, 16'h09c4);
		analog_ref_in = 16'h0af0;
		step(4);
		cmp(freq_ref_out, 16'h0af0);
		ref_hold_select_in = 1'b0;
		run_cmd_in = 1'b0;
		step(6);
		cmp(freq_ref_out, 16'h0000);
		{updown_limit_select_in, di_ext_ref_in, run_cmd_in} = 3'b101;
		step(8);
		cmp(freq_ref_out, 16'h0000);
		run_cmd_in = 1'b0;
		step(6);
	endtask

	initial begin
		{rst_n_in, run_cmd_in, power_fail_in, di_ramp_hold_in, di_up_in, di_down_in} = 6'h00;
		{di_ext_ref_in, di_fieldweak_in, ramp_hold_used_in, updown_used_in} = 4'h0;
		{ref_hold_select_in, updown_limit_select_in, analog_bias_used_in, class_400_in} = 4'h0;
		{vf_pattern_wr_in, param_initialize_in, pattern_point_wr_in} = 3'h0;
		di_offset_in = 3'h0;
		control_method_select_in = 3'h0;
		vf_pattern_data_in = 4'h0;
		fieldweak_voltage_level_in = FW_LEVEL_DEF;
		max_voltage_in = 10'h190;
		input_voltage_setting_in = 10'h0e6;
		ref_lower_limit_in = 11'h000;
		{offset_freq_one_in, offset_freq_two_in, offset_freq_three_in} = 36'h0;
		fieldweak_freq_limit_in = 12'h000;
		pattern_max_freq_in = 16'h1770;
		{active_ref_in, analog_ref_in, analog_bias_in, output_freq_in} = 64'h0;
		pattern_point_last_in = 16'h0000;
		step(12);
		rst_n_in = 1'b1;
		step(4);
		t_uv();
		t_vf();
		t_magnet();
		t_offsets();
		t_fw();
		t_hold();
		t_updown();
		give_verdict();
	end
endmodule
